/* File: inc/dtr_cfg.svh */
// Constants for the dual-tone receiver control block
`ifndef DTR_CFG_SVH
`define DTR_CFG_SVH
`define DTR_ADDR_W 4
`define DTR_DATA_W 8
`define DTR_OFF_CTRL 4'h0
`define DTR_OFF_CODE 4'h1
`define DTR_OFF_IRQ_STAT 4'h2
`define DTR_OFF_IRQ_MASK 4'h3
`define DTR_BIT_PWDN 0
`define DTR_BIT_INH 1
`define DTR_BIT_VALID 2
`define DTR_CTRL_RST 8'h01
`define DTR_IRQ_BIT_TONE 0
`define DTR_IRQ_BIT_IGN 1
`define DTR_ROW_W 2
`define DTR_COL_W 2
`define DTR_COL_EXT 2'h3
`define DTR_ROW_LAST 2'h3
`define DTR_COL_1209 2'h0
`define DTR_COL_1336 2'h1
`define DTR_COL_1477 2'h2
`define DTR_CODE_ZERO 4'hA
`define DTR_CODE_STAR 4'hB
`define DTR_CODE_HASH 4'hC
`define DTR_CODE_A 4'hD
`define DTR_CODE_D 4'h0
`endif

/* File: inc/dtr_pkg.sv */
// Types for the dual-tone receiver control block
package dtr_pkg;
    typedef enum logic [1:0] {
        DTR_IDLE = 2'b00,
        DTR_CHARGE = 2'b01,
        DTR_VALID = 2'b10,
        DTR_DISCH = 2'b11
    } dtr_state_t;
endpackage : dtr_pkg

/* File: inc/dtr_code_if.sv */
// Carries tone position and its derived code between modules
`timescale 1ns/1ps
interface dtr_code_if;
    logic [1:0] row;
    logic [1:0] col;
    logic [3:0] code;
    logic is_ext;
    modport map (input row, input col, output code, output is_ext);
    modport user (output row, output col, input code, input is_ext);
endinterface : dtr_code_if

/* File: rtl/dtr_code_map.sv */
// Row/column to 4-bit tone code mapping
`timescale 1ns/1ps
`include "dtr_cfg.svh"
module dtr_code_map
    import dtr_pkg::*;
(
    dtr_code_if.map cif
);
    always_comb
    begin
        cif.is_ext = (cif.col == `DTR_COL_EXT);
        if (cif.col == `DTR_COL_EXT)
        begin
            // A..D: 1101,1110,1111 then wrap to 0000
            cif.code = (cif.row == `DTR_ROW_LAST) ? `DTR_CODE_D
                     : 4'(`DTR_CODE_A + {2'b00, cif.row});
        end
        else if (cif.row == `DTR_ROW_LAST)
        begin
            case (cif.col)
                `DTR_COL_1209: cif.code = `DTR_CODE_STAR;
                `DTR_COL_1336: cif.code = `DTR_CODE_ZERO;
                default: cif.code = `DTR_CODE_HASH;
            endcase
        end
        else
        begin
            // Digit = row*3 + col + 1
            cif.code = 4'({cif.row, 1'b0} + {2'b00, cif.row} + {2'b00, cif.col} + 4'h1);
        end
    end
endmodule : dtr_code_map

/* File: rtl/dtr_receiver.sv */
// Dual-tone receiver steering, code latch and control register
`timescale 1ns/1ps
`include "dtr_cfg.svh"
// Summary of operation
// - Control bit 0 is power-down, set to 1 after reset.
// - Control bit 1 inhibits detection of extended characters A to D; resets 0.
// - Control bit 2 is the data-valid flag, set when a valid tone is received.
// - Control bits 7 to 3 always read zero.
// - A valid tone raises the peripheral interrupt request.
// - Digits 1 to 9 give their binary value as code.
// - Row 941 Hz gives 1010 for zero, 1011 star, 1100 hash.
// - Column 1633 Hz gives 1101,1110,1111,0000 for A-D, only without inhibit.
// - Steering output low with no tone, high once a valid tone is seen.
// - Code is generated only when steering sense crosses the threshold.
// - Valid output rises only after the code is latched.
// - Valid output drops when steering sense falls below threshold.
// - Code keeps its value until the next accepted tone.
module dtr_receiver
    import dtr_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    // Register port
    input wire logic [`DTR_ADDR_W-1:0] I_ADDR,
    input wire logic [`DTR_DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [`DTR_DATA_W-1:0] O_RDATA,
    // Tone detector side
    input wire logic I_TONE_PRESENT,
    input wire logic [1:0] I_TONE_ROW,
    input wire logic [1:0] I_TONE_COL,
    // Steering RC network
    output logic O_STEERING_DRIVE_OUT,
    input wire logic I_STEERING_RC_SENSE,
    // Results
    output logic [3:0] O_TONE_CODE_BITS,
    output logic O_TONE_VALID_OUT,
    output logic O_IRQ
);
    typedef struct packed {
        dtr_state_t state;
        logic rx_power_down;
        logic extended_char_inhibit;
        logic tone_valid_flag;
        logic [3:0] code;
        logic [3:0] pend_code;
        logic pend_ext;
        logic steer_drive;
        logic valid_out;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [`DTR_DATA_W-1:0] rdata;
    } dtr_regs_t;

    dtr_regs_t s_r;
    dtr_regs_t s_nxt;
    dtr_code_if cif ();
    logic sel_ctrl;
    logic sel_stat;
    logic sel_mask;
    logic accept;
    logic ignored;
    logic tone_ok;
    logic [`DTR_DATA_W-1:0] ctrl_view;

    assign cif.row = I_TONE_ROW;
    assign cif.col = I_TONE_COL;

    dtr_code_map u_map (
        .cif (cif)
    );

    always_comb
    begin
        sel_ctrl = (I_ADDR == `DTR_OFF_CTRL);
        sel_stat = (I_ADDR == `DTR_OFF_IRQ_STAT);
        sel_mask = (I_ADDR == `DTR_OFF_IRQ_MASK);
        // Bits 7..3 read zero
        ctrl_view = {5'h00, s_r.tone_valid_flag, s_r.extended_char_inhibit,
                     s_r.rx_power_down};
        // Tone usable only when powered up and not an inhibited A-D
        tone_ok = I_TONE_PRESENT && !s_r.rx_power_down &&
                  !(cif.is_ext && s_r.extended_char_inhibit);
        accept = 1'b0;
        ignored = 1'b0;
        s_nxt = s_r;

        case (s_r.state)
            DTR_IDLE:
            begin
                s_nxt.steer_drive = 1'b0;
                if (tone_ok)
                begin
                    s_nxt.steer_drive = 1'b1;
                    s_nxt.pend_code = cif.code;
                    s_nxt.pend_ext = cif.is_ext;
                    s_nxt.state = DTR_CHARGE;
                end
                else if (I_TONE_PRESENT && !s_r.rx_power_down)
                begin
                    ignored = 1'b1;
                end
            end
            DTR_CHARGE:
            begin
                if (!tone_ok)
                begin
                    s_nxt.steer_drive = 1'b0;
                    s_nxt.state = DTR_DISCH;
                end
                else if (I_STEERING_RC_SENSE)
                begin
                    // Threshold crossed: latch code now, valid next cycle
                    s_nxt.code = s_r.pend_code;
                    accept = 1'b1;
                    s_nxt.state = DTR_VALID;
                end
            end
            DTR_VALID:
            begin
                s_nxt.valid_out = 1'b1;
                if (!tone_ok)
                begin
                    s_nxt.steer_drive = 1'b0;
                end
                if (!I_STEERING_RC_SENSE)
                begin
                    s_nxt.valid_out = 1'b0;
                    s_nxt.steer_drive = 1'b0;
                    s_nxt.state = DTR_DISCH;
                end
            end
            DTR_DISCH:
            begin
                s_nxt.steer_drive = 1'b0;
                s_nxt.valid_out = 1'b0;
                if (!I_STEERING_RC_SENSE)
                begin
                    s_nxt.state = DTR_IDLE;
                end
            end
            default:
            begin
                s_nxt.state = DTR_IDLE;
            end
        endcase

        if (s_r.rx_power_down)
        begin
            // Abort any tone in progress; code stays
            s_nxt.steer_drive = 1'b0;
            s_nxt.valid_out = 1'b0;
            // Let a discharge finish, or it would stall here
            if (s_r.state == DTR_CHARGE || s_r.state == DTR_VALID)
            begin
                s_nxt.state = DTR_DISCH;
            end
        end

        // Register writes
        if (I_WR && sel_ctrl)
        begin
            s_nxt.rx_power_down = I_WDATA[`DTR_BIT_PWDN];
            s_nxt.extended_char_inhibit = I_WDATA[`DTR_BIT_INH];
            s_nxt.tone_valid_flag = I_WDATA[`DTR_BIT_VALID];
        end
        if (I_WR && sel_mask)
        begin
            s_nxt.irq_mask = I_WDATA[1:0];
        end
        if (I_WR && sel_stat)
        begin
            s_nxt.irq_stat = s_r.irq_stat & ~I_WDATA[1:0];
        end

        // Hardware set wins over a same-cycle clear
        if (accept)
        begin
            s_nxt.tone_valid_flag = 1'b1;
            s_nxt.irq_stat[`DTR_IRQ_BIT_TONE] = 1'b1;
        end
        if (ignored)
        begin
            s_nxt.irq_stat[`DTR_IRQ_BIT_IGN] = 1'b1;
        end

        // Read data one cycle after the strobe
        s_nxt.rdata = '0;
        if (I_RD)
        begin
            case (I_ADDR)
                `DTR_OFF_CTRL: s_nxt.rdata = ctrl_view;
                `DTR_OFF_CODE: s_nxt.rdata = {4'h0, s_r.code};
                `DTR_OFF_IRQ_STAT: s_nxt.rdata = {6'h00, s_r.irq_stat};
                `DTR_OFF_IRQ_MASK: s_nxt.rdata = {6'h00, s_r.irq_mask};
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            s_r <= '0;
            s_r.state <= DTR_IDLE;
            s_r.rx_power_down <= 1'b1;
            s_r.extended_char_inhibit <= 1'b0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign O_RDATA = s_r.rdata;
    assign O_STEERING_DRIVE_OUT = s_r.steer_drive;
    assign O_TONE_CODE_BITS = s_r.code;
    assign O_TONE_VALID_OUT = s_r.valid_out;
    assign O_IRQ = |(s_r.irq_stat & s_r.irq_mask);
endmodule : dtr_receiver

/* File: tb/dtr_rc_model.sv */
// Steering RC network seen through the threshold comparator
`timescale 1ns/1ps
module dtr_rc_model (
    input logic i_clk,
    input logic i_drive,
    input logic [3:0] i_dly,
    output logic o_sense = 1'b0
);
    logic [3:0] cnt = 4'h0;
    // Node crosses the threshold only after the RC delay
    always @(posedge i_clk)
    begin
        cnt <= (i_drive == o_sense || cnt == i_dly) ? 4'h0 : cnt + 4'h1;
        if (i_drive != o_sense && cnt == i_dly)
            o_sense <= i_drive;
    end
endmodule : dtr_rc_model

/* File: tb/dtr_receiver_monitor.sv */
// Port checker for the dual-tone receiver
`timescale 1ns/1ps
module dtr_receiver_monitor (
    input logic I_CLK_SYS, I_RST_B, I_WR, I_RD, I_TONE_PRESENT, I_STEERING_RC_SENSE,
    input logic [3:0] I_ADDR, O_TONE_CODE_BITS,
    input logic [7:0] I_WDATA, O_RDATA,
    input logic [1:0] I_TONE_ROW, I_TONE_COL,
    input logic O_STEERING_DRIVE_OUT, O_TONE_VALID_OUT, O_IRQ
);
    wire drv = O_STEERING_DRIVE_OUT;
    wire sns = I_STEERING_RC_SENSE;
    wire vld = O_TONE_VALID_OUT;
    wire [3:0] code = O_TONE_CODE_BITS;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_B);
    rd_idle_a: assert property (!I_RD |=> O_RDATA == 8'h00)
        else $error("read data not idle");
    ctrl_zero_a: assert property (I_RD && I_ADDR == 4'h0 |=> O_RDATA[7:3] == 5'h00)
        else $error("control high bits set");
    drv_idle_a: assert property (!I_TONE_PRESENT && !drv |=> !drv)
        else $error("drive rose with no tone");
    vld_drop_a: assert property (vld && !sns |=> !vld)
        else $error("valid held after sense fell");
    code_hold_a: assert property (!drv |=> $stable(code))
        else $error("code moved without a tone");
    code_first_a: assert property ($rose(vld) |-> $stable(code))
        else $error("code moved as valid rose");
    vld_sense_a: assert property ($rose(vld) |-> $past(sns, 2))
        else $error("valid rose without sense");
    code_cause_a: assert property ($changed(code) |-> $past(drv) && $past(sns))
        else $error("code latched without steering");
    cv_accept: cover property ($rose(vld));
    cv_drop: cover property ($fell(vld));
    cv_irq: cover property ($rose(O_IRQ));
endmodule : dtr_receiver_monitor
bind dtr_receiver dtr_receiver_monitor u_dtr_receiver_monitor (.*);

/* File: tb/dtr_receiver_tb.sv */
// Self-checking bench for the dual-tone receiver
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module dtr_receiver_tb;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, pres = 0, drv, sns, vld, irq;
    logic [3:0] addr = 4'h0, code, dly = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [1:0] row = 2'h0, col = 2'h0;
    logic [3:0] tbl [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
        4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};
    int mismatches = 0, n_checks = 0;
    dtr_receiver u_dtr_receiver (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TONE_PRESENT(pres),
        .I_TONE_ROW(row), .I_TONE_COL(col), .O_STEERING_DRIVE_OUT(drv),
        .I_STEERING_RC_SENSE(sns), .O_TONE_CODE_BITS(code), .O_TONE_VALID_OUT(vld),
        .O_IRQ(irq));
    dtr_rc_model u_dtr_rc_model (.i_clk(clk), .i_drive(drv), .i_dly(dly), .o_sense(sns));
    initial forever #2 clk = ~clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w) `CHK(rdata, d)
    endtask : bus
    task automatic wait_vld(input logic want);
        for (int k = 0; k < 40 && vld !== want; k++)
            @(posedge clk) #1;
    endtask : wait_vld
    // Hold the tone until valid, then remove it and let the node discharge
    task automatic send(input int r, input int c, input logic ok);
        `CHK(drv, 1'b0)
        @(posedge clk);
        row <= 2'(r);
        col <= 2'(c);
        pres <= 1'b1;
        @(posedge clk) #1;
        `CHK(drv, ok)
        wait_vld(1'b1);
        `CHK(vld, ok)
        if (vld !== ok) wrap_up();
        @(posedge clk);
        pres <= 1'b0;
        wait_vld(1'b0);
        `CHK(vld, 1'b0)
        `CHK(drv, 1'b0)
        if (vld !== 1'b0) wrap_up();
    endtask : send
    task automatic t_codes();
        bus(1, 4'h0, 8'h00);
        bus(1, 4'h3, 8'h03);
        bus(0, 4'h3, 8'h03);
        for (int i = 0; i < 16; i++)
        begin
            dly = 4'(i % 8);
            send(i / 4, i % 4, 1'b1);
            `CHK(code, tbl[i])
            `CHK(irq, 1'b1)
            bus(0, 4'h1, {4'h0, tbl[i]});
            bus(0, 4'h0, 8'h04);
            bus(0, 4'h0, 8'h04);
            bus(1, 4'h2, 8'h03);
            bus(1, 4'h0, 8'h00);
            bus(0, 4'h0, 8'h00);
            `CHK(irq, 1'b0)
        end
        $display("codes done");
    endtask : t_codes
    task automatic t_block();
        send(1, 1, 1'b1);
        bus(1, 4'h2, 8'h03);
        bus(1, 4'h3, 8'h01);
        bus(1, 4'h0, 8'h02);
        send(1, 3, 1'b0);
        `CHK(code, 4'h5)
        `CHK(irq, 1'b0)
        bus(0, 4'h2, 8'h02);
        bus(0, 4'h0, 8'h02);
        bus(1, 4'h2, 8'h03);
        bus(1, 4'h3, 8'h03);
        bus(1, 4'h0, 8'h01);
        send(2, 0, 1'b0);
        `CHK(code, 4'h5)
        `CHK(irq, 1'b0)
        bus(0, 4'h2, 8'h00);
        $display("block done");
    endtask : t_block
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, 4'h0, 8'h01);
        bus(0, 4'h7, 8'h00);
        $display("reset done");
        t_codes();
        t_block();
        wrap_up();
    end
endmodule : dtr_receiver_tb
